/* lsg_gating_ctrl.sv */
`timescale 1ns/1ps
// Contract
// - enter skip mode after current sense below light-load reference for 20ms
// - in skip mode remove two of every five gate pulses
// - light-load reference pin grounded disables skip mode
// - pulse-group on: feedback below 0.1V stops gates after high-side cycle ends
// - stopped gates resume as soon as feedback rises above 0.15V
// - first pulse after resume is a shortened high-side pulse
// - rectifier gate ends on on-time expiry or advanced primary-off, first wins
// - line sense above reference: rectifier gate on 250ns after its primary gate
// - rectifier turn-off taken from the advanced primary-off signal
// - rectifier off in soft start; enabled via ramp after ramp level >1.9V 20ms
// - feedback below 0.2V disables rectifier at once; above 0.7V restarts via ramp
// - ramp level below 1.8V disables; restart via ramp 10ms after above 1.9V
// - current sense above 0.9V disables rectifier; below 0.6V restarts via ramp
// - soft-start, feedback and current-sense disables also pull the rectifier on-time pin to zero
// - sense drop 0.55V to below 0.30V within 1ms holds rectifier off 1ms
// - on-time pin held at zero stops rectifier; restart via ramp above 1.75V
// - ramp: eighth duty for 16 cycles, 7 steps of 16, full after 128
// - option pin sampled once after power-up enables pulse-group mode
module lsg_gating_ctrl
  import lsg_pkg::*;
#(
  parameter int unsigned SKIP_WAIT_CYC = LSG_T_SKIP_MS * LSG_MS_CYC,
  parameter int unsigned SS_WAIT_CYC   = LSG_T_SS_MS * LSG_MS_CYC,
  parameter int unsigned OCP_WAIT_CYC  = LSG_T_OCP_MS * LSG_MS_CYC,
  parameter int unsigned DROP_CYC      = LSG_T_DROP_MS * LSG_MS_CYC
) (
  input  logic        ref_clk_i,
  input  logic        nrst_i,
  input  lsg_flags_t  flags_i,
  input  logic [7:0]  addr_i,
  input  logic [31:0] wdata_i,
  input  logic        wr_i,
  input  logic        rd_i,
  output logic [31:0] rdata_o,
  output logic [1:0]  gate_o,
  output logic [1:0]  sr_o,
  output logic        srd_pull_o
);
  localparam logic [LSG_TW-1:0] SKIP_N = LSG_TW'(SKIP_WAIT_CYC - 1);
  localparam logic [LSG_TW-1:0] SS_N   = LSG_TW'(SS_WAIT_CYC - 1);
  localparam logic [LSG_TW-1:0] OCP_N  = LSG_TW'(OCP_WAIT_CYC - 1);
  localparam logic [LSG_TW-1:0] DROP_N = LSG_TW'(DROP_CYC);
  localparam logic [5:0]        DLY_N  = 6'(LSG_SRDLY_CYC - 1);
  localparam int                DLY    = LSG_SRDLY_CYC;

  lsg_flags_t        s1_reg, f_reg;
  lsg_ctrl_t         ctrl_reg;
  lsg_stat_t         stat;
  logic [31:0]       rdata_reg;
  logic [1:0]        osc_d_reg, ton_d_reg, adv_d_reg;
  logic [1:0]        gate_reg, sr_reg, pend_reg, ramp_cut;
  logic [5:0]        dly_reg [2];
  logic [LSG_PW-1:0] sr_cnt_reg [2];
  logic [LSG_PW-1:0] hi_cnt_reg, meas_reg;
  logic [LSG_TW-1:0] skip_cnt_reg, ss_cnt_reg, win_reg, hold_reg;
  logic [2:0]        slot_reg, opt_cnt_reg;
  logic [6:0]        ramp_cnt_reg;
  logic              skip_reg, opt_done_reg, pg_en_reg;
  logic              pg_pend_reg, pg_stop_reg, pg_wait_hi_reg, pg_short_reg;
  logic              ss_ok_reg, ss_seen_reg, fb_dis_reg, cs_dis_reg, ext_dis_reg;
  logic              srd_pull_reg, ramp_done_reg;

  // two-stage synchroniser; only the second stage is used
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_reg <= '0;
      f_reg  <= '0;
    end else begin
      s1_reg <= flags_i;
      f_reg  <= s1_reg;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      osc_d_reg <= 2'h0;
      ton_d_reg <= 2'h0;
      adv_d_reg <= 2'h0;
    end else begin
      osc_d_reg <= f_reg.osc;
      ton_d_reg <= f_reg.ton_end;
      adv_d_reg <= f_reg.adv_off;
    end
  end

  wire [1:0] rise     = f_reg.osc & ~osc_d_reg;
  wire [1:0] fall     = ~f_reg.osc & osc_d_reg;
  // edges, so a timer level left high from the last pulse cannot block the next one
  wire [1:0] off_ev   = (f_reg.ton_end & ~ton_d_reg) | (f_reg.adv_off & ~adv_d_reg);
  wire       skip_ok  = ctrl_reg.skip_allow & ~f_reg.vmc_gnd;
  wire       drop_now = skip_reg & ((slot_reg == LSG_SKIP_A) | (slot_reg == LSG_SKIP_B));
  wire [1:0] pulse_en = {~pg_wait_hi_reg, 1'b1} & {2{~drop_now & ~pg_stop_reg}};
  wire [1:0] cut      = {1'b0, pg_short_reg & (hi_cnt_reg >= (meas_reg >> 1))};

  // option strap caught once, a few cycles after release of reset
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      opt_cnt_reg  <= 3'h0;
      opt_done_reg <= 1'b0;
      pg_en_reg    <= 1'b0;
    end else if (!opt_done_reg) begin
      opt_cnt_reg <= opt_cnt_reg + 3'h1;
      if (opt_cnt_reg == LSG_OPT_WAIT) begin
        opt_done_reg <= 1'b1;
        pg_en_reg    <= f_reg.opt_gt_1p0;
      end
    end
  end

  // skip-cycle entry and exit
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      skip_reg     <= 1'b0;
      skip_cnt_reg <= '0;
    end else if (!skip_ok || f_reg.cs_hi_leave) begin
      skip_reg     <= 1'b0;
      skip_cnt_reg <= '0;
    end else if (!f_reg.cs_lo_enter) begin
      skip_cnt_reg <= '0;
    end else if (skip_cnt_reg == SKIP_N) begin
      skip_reg <= 1'b1;
    end else begin
      skip_cnt_reg <= skip_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      slot_reg <= 3'h0;
    end else if (|rise) begin
      slot_reg <= (slot_reg == LSG_SKIP_LAST) ? 3'h0 : slot_reg + 3'h1;
    end
  end

  // pulse-group stop and resume
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pg_pend_reg    <= 1'b0;
      pg_stop_reg    <= 1'b0;
      pg_wait_hi_reg <= 1'b0;
      pg_short_reg   <= 1'b0;
    end else if (!pg_en_reg) begin
      pg_pend_reg    <= 1'b0;
      pg_stop_reg    <= 1'b0;
      pg_wait_hi_reg <= 1'b0;
      pg_short_reg   <= 1'b0;
    end else begin
      if (pg_stop_reg) begin
        if (f_reg.fb_gt_0p15) begin
          pg_stop_reg    <= 1'b0;
          pg_wait_hi_reg <= 1'b1;
        end
      end else if (pg_pend_reg && fall[0]) begin
        pg_stop_reg <= 1'b1;
        pg_pend_reg <= 1'b0;
      end else if (f_reg.fb_lt_0p1) begin
        pg_pend_reg <= 1'b1;
      end
      if (rise[0] && pulse_en[0]) begin
        pg_short_reg   <= pg_wait_hi_reg;
        pg_wait_hi_reg <= 1'b0;
      end
    end
  end

  // primary gates; the shortened pulse is half the last full high-side pulse
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      gate_reg <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (rise[i]) begin
          gate_reg[i] <= pulse_en[i];
        end else if (fall[i] || pg_stop_reg || cut[i]) begin
          gate_reg[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hi_cnt_reg <= '0;
      meas_reg   <= LSG_MEAS_RST;
    end else begin
      if (rise[0]) begin
        hi_cnt_reg <= '0;
      end else if (gate_reg[0]) begin
        hi_cnt_reg <= hi_cnt_reg + 1'b1;
      end
      if (fall[0] && gate_reg[0] && !pg_short_reg) begin
        meas_reg <= hi_cnt_reg;
      end
    end
  end

  // rectifier disable conditions
  wire [LSG_TW-1:0] ss_lim  = ss_seen_reg ? OCP_N : SS_N;
  wire              int_dis = ~ss_ok_reg | fb_dis_reg | cs_dis_reg;
  wire              sr_dis  = int_dis | (hold_reg != '0) | ext_dis_reg | ~ctrl_reg.sr_allow;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ss_ok_reg   <= 1'b0;
      ss_seen_reg <= 1'b0;
      ss_cnt_reg  <= '0;
    end else if (f_reg.ss_lt_1p8) begin
      ss_ok_reg  <= 1'b0;
      ss_cnt_reg <= '0;
    end else if (!f_reg.ss_gt_1p9) begin
      ss_cnt_reg <= '0;
    end else if (!ss_ok_reg) begin
      if (ss_cnt_reg == ss_lim) begin
        ss_ok_reg   <= 1'b1;
        ss_seen_reg <= 1'b1;
        ss_cnt_reg  <= '0;
      end else begin
        ss_cnt_reg <= ss_cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fb_dis_reg   <= 1'b0;
      cs_dis_reg   <= 1'b0;
      ext_dis_reg  <= 1'b0;
      srd_pull_reg <= 1'b1;
    end else begin
      fb_dis_reg   <= f_reg.fb_lt_0p2 | (fb_dis_reg & ~f_reg.fb_gt_0p7);
      cs_dis_reg   <= f_reg.cs_gt_0p9 | (cs_dis_reg & ~f_reg.cs_lt_0p6);
      ext_dis_reg  <= f_reg.srd_zero | (ext_dis_reg & ~f_reg.srd_gt_1p75);
      srd_pull_reg <= int_dis;
    end
  end

  // fast-drop detector: the window is cleared on a hit so the hold is exactly one period
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      win_reg  <= '0;
      hold_reg <= '0;
    end else if ((win_reg != '0) && f_reg.cs_lt_0p30) begin
      win_reg  <= '0;
      hold_reg <= DROP_N;
    end else begin
      win_reg  <= f_reg.cs_gt_0p55 ? DROP_N : win_reg - (win_reg != '0 ? 1'b1 : 1'b0);
      hold_reg <= hold_reg - (hold_reg != '0 ? 1'b1 : 1'b0);
    end
  end

  // duty ramp, restarted by every disable
  wire [4:0]          ramp_lvl = ramp_done_reg ? LSG_LVL_FULL :
                                 5'(ramp_cnt_reg / LSG_RAMP_STEP_CYC) * LSG_LVL_STEP + LSG_LVL_STEP;
  wire [17:0]         prod     = meas_reg * ramp_lvl;
  wire [LSG_PW-1:0]   sr_lim   = prod[16:4];

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ramp_cnt_reg  <= 7'h00;
      ramp_done_reg <= 1'b0;
    end else if (sr_dis) begin
      ramp_cnt_reg  <= 7'h00;
      ramp_done_reg <= 1'b0;
    end else if (rise[0] && !ramp_done_reg) begin
      if (ramp_cnt_reg == LSG_RAMP_LAST) begin
        ramp_done_reg <= 1'b1;
      end else begin
        ramp_cnt_reg <= ramp_cnt_reg + 7'h01;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      ramp_cut[i] = ~ramp_done_reg & sr_reg[i] & (sr_cnt_reg[i] >= sr_lim);
    end
  end

  wire [1:0] sr_off = {2{sr_dis}} | off_ev | ramp_cut;
  wire [1:0] sr_go  = rise & pulse_en & {2{~sr_dis}};

  // rectifier gates: turn-off has priority over a new start
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sr_reg   <= 2'h0;
      pend_reg <= 2'h0;
      for (int i = 0; i < 2; i++) begin
        dly_reg[i]    <= 6'h00;
        sr_cnt_reg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (sr_off[i]) begin
          sr_reg[i]   <= 1'b0;
          pend_reg[i] <= 1'b0;
        end else if (sr_go[i]) begin
          sr_reg[i]     <= ~f_reg.line_hi;
          pend_reg[i]   <= f_reg.line_hi;
          dly_reg[i]    <= 6'h00;
          sr_cnt_reg[i] <= '0;
        end else if (pend_reg[i]) begin
          if (dly_reg[i] == DLY_N) begin
            sr_reg[i]   <= 1'b1;
            pend_reg[i] <= 1'b0;
          end else begin
            dly_reg[i] <= dly_reg[i] + 6'h01;
          end
        end else if (sr_reg[i]) begin
          sr_cnt_reg[i] <= sr_cnt_reg[i] + 1'b1;
        end
      end
    end
  end

  // register port
  wire wr_ctrl = wr_i & (addr_i == LSG_REG_CTRL);
  assign stat = '{skip: skip_reg, pg_en: pg_en_reg, pg_stop: pg_stop_reg,
                  pg_wait_hi: pg_wait_hi_reg, ss_ok: ss_ok_reg, fb_dis: fb_dis_reg,
                  cs_dis: cs_dis_reg, drop_hold: (hold_reg != '0), ext_dis: ext_dis_reg,
                  srd_pull: srd_pull_reg, ramp_done: ramp_done_reg, ramp_cnt: ramp_cnt_reg};
  wire [31:0] rd_mux = (addr_i == LSG_REG_CTRL) ? {30'h0, ctrl_reg} :
                       (addr_i == LSG_REG_STAT) ? 32'(stat) : 32'h0;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_reg  <= LSG_CTRL_RST;
      rdata_reg <= 32'h0;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= lsg_ctrl_t'(wdata_i[1:0]);
      end
      rdata_reg <= rd_i ? rd_mux : 32'h0;
    end
  end

  assign rdata_o    = rdata_reg;
  assign gate_o     = gate_reg;
  assign sr_o       = sr_reg;
  assign srd_pull_o = srd_pull_reg;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  property p_skip_enter; $rose(skip_reg) |-> $past(f_reg.cs_lo_enter) && $past(skip_cnt_reg) == SKIP_N; endproperty
  a_skip_enter: assert property (p_skip_enter) else $error("skip entered early");
  property p_skip_drop; rise[0] && skip_reg && (slot_reg == LSG_SKIP_A || slot_reg == LSG_SKIP_B) |=> !gate_reg[0];
  endproperty
  a_skip_drop: assert property (p_skip_drop) else $error("skip slot not removed");
  property p_skip_off; f_reg.vmc_gnd |=> !skip_reg; endproperty
  a_skip_off: assert property (p_skip_off) else $error("skip with grounded reference");
  property p_pg_quiet; pg_stop_reg |=> gate_reg == 2'h0; endproperty
  a_pg_quiet: assert property (p_pg_quiet) else $error("gate active while stopped");
  property p_pg_resume; pg_stop_reg && f_reg.fb_gt_0p15 |=> !pg_stop_reg && pg_wait_hi_reg; endproperty
  a_pg_resume: assert property (p_pg_resume) else $error("no resume");
  property p_pg_first; pg_wait_hi_reg && rise[1] |=> !gate_reg[1]; endproperty
  a_pg_first: assert property (p_pg_first) else $error("low pulse first after resume");
  property p_sr_off; sr_reg[0] && off_ev[0] |=> !sr_reg[0]; endproperty
  a_sr_off: assert property (p_sr_off) else $error("rectifier not ended");
  property p_sr_dly; $rose(sr_reg[0]) && $past(pend_reg[0]) |-> $past(gate_reg[0], DLY) && !$past(gate_reg[0], DLY + 1);
  endproperty
  a_sr_dly: assert property (p_sr_dly) else $error("turn-on delay wrong");
  property p_pull; fb_dis_reg || cs_dis_reg || !ss_ok_reg |=> srd_pull_reg && sr_reg == 2'h0; endproperty
  a_pull: assert property (p_pull) else $error("internal disable not applied");
  property p_drop; win_reg != '0 && f_reg.cs_lt_0p30 |=> ##1 sr_reg == 2'h0 && hold_reg != '0; endproperty
  a_drop: assert property (p_drop) else $error("fast drop not held");
  property p_ramp; $rose(ramp_done_reg) |-> $past(ramp_cnt_reg) == LSG_RAMP_LAST && $past(rise[0]); endproperty
  a_ramp: assert property (p_ramp) else $error("ramp length wrong");
  property p_opt; opt_done_reg |=> $stable(pg_en_reg); endproperty
  a_opt: assert property (p_opt) else $error("option resampled");
  c_skip: cover property ($rose(skip_reg));
  c_pg: cover property ($fell(pg_stop_reg));
  c_ramp: cover property ($rose(ramp_done_reg));
  c_dly: cover property ($rose(sr_reg[1]) && $past(pend_reg[1]));
endmodule : lsg_gating_ctrl

/* lsg_pkg.sv */
package lsg_pkg;
  // clock and times
  localparam int LSG_CLK_MHZ    = 250;
  localparam int LSG_MS_CYC     = LSG_CLK_MHZ * 1000;
  localparam int LSG_T_SKIP_MS  = 20;
  localparam int LSG_T_SS_MS    = 20;
  localparam int LSG_T_OCP_MS   = 10;
  localparam int LSG_T_DROP_MS  = 1;
  localparam int LSG_T_SRDLY_NS = 250;
  localparam int LSG_SRDLY_CYC  = (LSG_T_SRDLY_NS * LSG_CLK_MHZ + 999) / 1000;
  localparam int LSG_RAMP_STEP_CYC = 16;
  // widths
  localparam int LSG_TW = 23;
  localparam int LSG_PW = 13;
  // pulse skipping: slots 0..4, slots 1 and 3 removed
  localparam logic [2:0] LSG_SKIP_LAST = 3'h4;
  localparam logic [2:0] LSG_SKIP_A    = 3'h1;
  localparam logic [2:0] LSG_SKIP_B    = 3'h3;
  // duty ramp, level in sixteenths of the last primary on-time
  localparam logic [6:0] LSG_RAMP_LAST = 7'h7F;
  localparam logic [4:0] LSG_LVL_STEP  = 5'h02;
  localparam logic [4:0] LSG_LVL_FULL  = 5'h10;
  localparam logic [2:0] LSG_OPT_WAIT  = 3'h3;
  localparam logic [LSG_PW-1:0] LSG_MEAS_RST = 13'h1FFF;
  // register map
  localparam logic [7:0] LSG_REG_CTRL = 8'h00;
  localparam logic [7:0] LSG_REG_STAT = 8'h04;

  typedef struct packed {
    logic sr_allow;
    logic skip_allow;
  } lsg_ctrl_t;
  localparam lsg_ctrl_t LSG_CTRL_RST = 2'h3;

  typedef struct packed {
    logic       cs_lo_enter;
    logic       cs_hi_leave;
    logic       vmc_gnd;
    logic       fb_lt_0p1;
    logic       fb_gt_0p15;
    logic       fb_lt_0p2;
    logic       fb_gt_0p7;
    logic       ss_gt_1p9;
    logic       ss_lt_1p8;
    logic       cs_gt_0p9;
    logic       cs_lt_0p6;
    logic       cs_gt_0p55;
    logic       cs_lt_0p30;
    logic       line_hi;
    logic       srd_zero;
    logic       srd_gt_1p75;
    logic       opt_gt_1p0;
    logic [1:0] osc;
    logic [1:0] ton_end;
    logic [1:0] adv_off;
  } lsg_flags_t;

  typedef struct packed {
    logic       skip;
    logic       pg_en;
    logic       pg_stop;
    logic       pg_wait_hi;
    logic       ss_ok;
    logic       fb_dis;
    logic       cs_dis;
    logic       drop_hold;
    logic       ext_dis;
    logic       srd_pull;
    logic       ramp_done;
    logic [6:0] ramp_cnt;
  } lsg_stat_t;
endpackage : lsg_pkg

/* lsg_drv_model.sv */
`timescale 1ns/1ps
// oscillator and driver side: alternating primary phases, advanced-off pulses and the external kill switch
module lsg_drv_model
  import lsg_pkg::*;
#(
  parameter int HI   = 100,
  parameter int DEAD = 4,
  parameter int ADV  = 8
) (
  input  wire logic       clk_i,
  input  wire logic       run_i,
  input  wire logic       kill_i,
  input  wire logic       pull_i,
  output logic      [1:0] osc_o,
  output logic      [1:0] ton_end_o,
  output logic      [1:0] adv_off_o,
  output logic            srd_zero_o
);
  int cnt;
  // either the kill switch or the device's own pull holds the pin at zero
  assign srd_zero_o = kill_i | pull_i;
  // on-time timer set longer than a phase, so the advanced off always wins here
  assign ton_end_o  = 2'h0;
  always_ff @(posedge clk_i) begin
    if (!run_i) begin
      cnt       <= 0;
      osc_o     <= 2'h0;
      adv_off_o <= 2'h0;
    end else begin
      cnt       <= (cnt == 2 * (HI + DEAD) - 1) ? 0 : cnt + 1;
      // phases never overlap: dead time after each
      osc_o     <= {cnt >= HI + DEAD && cnt < 2 * HI + DEAD, cnt < HI};
      // advanced off leads each primary fall by ADV cycles
      adv_off_o <= {cnt >= 2 * HI + DEAD - ADV && cnt < 2 * HI + DEAD, cnt >= HI - ADV && cnt < HI};
    end
  end
endmodule : lsg_drv_model

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import lsg_pkg::*;
  logic        ref_clk_i = 1'b0;
  logic        nrst_i    = 1'b0;
  lsg_flags_t  fl;
  lsg_flags_t  flags;
  logic [7:0]  addr  = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr    = 1'b0;
  logic        rd    = 1'b0;
  logic        kill  = 1'b0;
  logic [31:0] rdata;
  logic [31:0] d;
  logic [1:0]  gate, sr, osc, ton, adv;
  logic [1:0]  gp = 2'h0;
  logic [1:0]  sp = 2'h0;
  logic        pull, srz;
  int          n_errors = 0, samples_checked = 0, cyc = 0, n_g = 0, n_s = 0;
  int          t_g0 = 0, t_s0 = 0, w_g0 = 0, w_s0 = 0;

  always #2 ref_clk_i = ~ref_clk_i;

  always_comb begin
    flags             = fl;
    flags.osc         = osc;
    flags.ton_end     = ton;
    flags.adv_off     = adv;
    flags.srd_zero    = srz;
    flags.srd_gt_1p75 = ~srz;
  end

  lsg_gating_ctrl #(.SKIP_WAIT_CYC(40), .SS_WAIT_CYC(40), .OCP_WAIT_CYC(20), .DROP_CYC(10)) uut (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .flags_i(flags), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .gate_o(gate), .sr_o(sr), .srd_pull_o(pull));

  lsg_drv_model drv (
    .clk_i(ref_clk_i), .run_i(nrst_i), .kill_i(kill), .pull_i(pull),
    .osc_o(osc), .ton_end_o(ton), .adv_off_o(adv), .srd_zero_o(srz));

  // pulse counts and widths, one edge late on both ends so widths stay exact
  always @(posedge ref_clk_i) begin
    gp <= gate;
    sp <= sr;
    cyc <= cyc + 1;
    if (gate[0] && !gp[0]) begin
      n_g++;
      t_g0 <= cyc;
    end
    if (gate[1] && !gp[1]) n_g++;
    if (!gate[0] && gp[0]) w_g0 <= cyc - t_g0;
    if (sr[0] && !sp[0]) begin
      n_s++;
      t_s0 <= cyc;
    end
    if (sr[1] && !sp[1]) n_s++;
    if (!sr[0] && sp[0]) w_s0 <= cyc - t_s0;
    if (cyc == 90000) begin
      n_errors++;
      end_sim();
    end
  end

  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  task wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk_i);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= v;
    @(posedge ref_clk_i);
    wr <= 1'b0;
  endtask : wr_reg

  task rd_reg(input logic [7:0] a);
    @(posedge ref_clk_i);
    rd   <= 1'b1;
    addr <= a;
    @(posedge ref_clk_i);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  // window of p whole periods, bounded by low-side phase ends
  task win(input int p);
    @(negedge osc[1]);
    #1 n_g = 0;
    n_s = 0;
    repeat (p) @(negedge osc[1]);
    #1;
  endtask : win

  task t_skip;
    win(5);
    chk("gates normal", n_g, 32'hA);
    chk("gate width", w_g0, 32'h64);
    @(posedge ref_clk_i);
    fl.cs_lo_enter <= 1'b1;
    fl.cs_hi_leave <= 1'b0;
    repeat (60) @(posedge ref_clk_i);
    win(5);
    chk("gates skip", n_g, 32'h6);
    wr_reg(LSG_REG_CTRL, 32'h2);
    win(1);
    win(5);
    chk("gates skip off", n_g, 32'hA);
    wr_reg(LSG_REG_CTRL, 32'h3);
    repeat (60) @(posedge ref_clk_i);
    win(5);
    chk("gates skip again", n_g, 32'h6);
    @(posedge ref_clk_i);
    fl.cs_lo_enter <= 1'b0;
    fl.cs_hi_leave <= 1'b1;
    win(1);
    win(5);
    chk("gates left", n_g, 32'hA);
    @(posedge ref_clk_i);
    fl.vmc_gnd     <= 1'b1;
    fl.cs_lo_enter <= 1'b1;
    fl.cs_hi_leave <= 1'b0;
    repeat (100) @(posedge ref_clk_i);
    win(5);
    chk("gates ref grounded", n_g, 32'hA);
    fl.vmc_gnd     <= 1'b0;
    fl.cs_lo_enter <= 1'b0;
    fl.cs_hi_leave <= 1'b1;
    $display("test skip done");
  endtask : t_skip

  task t_pg;
    int i;
    @(posedge ref_clk_i);
    fl.fb_lt_0p1  <= 1'b1;
    fl.fb_lt_0p2  <= 1'b1;
    fl.fb_gt_0p15 <= 1'b0;
    fl.fb_gt_0p7  <= 1'b0;
    win(1);
    win(3);
    chk("gates stopped", n_g, 32'h0);
    @(negedge osc[1]);
    #1 n_g = 0;
    fl.fb_lt_0p1  <= 1'b0;
    fl.fb_gt_0p15 <= 1'b1;
    for (i = 0; i < 600 && gate[0] !== 1'b1; i++) @(posedge ref_clk_i);
    #1 chk("pulses up to first high side", n_g, 32'h1);
    for (i = 0; i < 600 && gate[0] !== 1'b0; i++) @(posedge ref_clk_i);
    @(posedge ref_clk_i);
    #1 chk("first pulse short", w_g0 < 60, 1'b1);
    chk("resumed", n_g, 32'h1);
    fl.fb_lt_0p2 <= 1'b0;
    fl.fb_gt_0p7 <= 1'b1;
    $display("test pulse group done");
  endtask : t_pg

  task t_sr;
    chk("pull in soft start", pull, 1'b1);
    win(2);
    chk("rect in soft start", n_s, 32'h0);
    @(posedge ref_clk_i);
    fl.ss_lt_1p8 <= 1'b0;
    fl.ss_gt_1p9 <= 1'b1;
    repeat (60) @(posedge ref_clk_i);
    chk("pull released", pull, 1'b0);
    win(1);
    chk("rect enabled", n_s, 32'h2);
    chk("ramp first width", w_s0 >= 10 && w_s0 <= 14, 1'b1);
    win(130);
    chk("full width", w_s0 >= 88 && w_s0 < 100, 1'b1);
    rd_reg(LSG_REG_STAT);
    chk("ramp done", d[7], 1'b1);
    fl.line_hi <= 1'b1;
    win(1);
    chk("turn-on delay", t_s0 - t_g0, LSG_SRDLY_CYC);
    fl.line_hi   <= 1'b0;
    fl.fb_lt_0p2 <= 1'b1;
    fl.fb_gt_0p7 <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    #1 chk("rect off fb low", sr, 2'h0);
    chk("pull fb low", pull, 1'b1);
    win(2);
    chk("rect stays off", n_s, 32'h0);
    fl.fb_lt_0p2 <= 1'b0;
    fl.fb_gt_0p7 <= 1'b1;
    win(1);
    win(1);
    chk("restart ramp", w_s0 >= 10 && w_s0 <= 14, 1'b1);
    kill <= 1'b1;
    win(1);
    win(2);
    chk("rect killed", n_s, 32'h0);
    kill <= 1'b0;
    win(1);
    win(1);
    chk("kill restart", n_s == 2 && w_s0 <= 14, 1'b1);
    $display("test rectifier done");
  endtask : t_sr

  task t_prot;
    @(posedge ref_clk_i);
    fl.cs_gt_0p9 <= 1'b1;
    fl.cs_lt_0p6 <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    #1 chk("rect off cs high", sr, 2'h0);
    chk("pull cs high", pull, 1'b1);
    @(posedge ref_clk_i);
    fl.cs_gt_0p9 <= 1'b0;
    fl.cs_lt_0p6 <= 1'b1;
    win(1);
    win(1);
    chk("cs restart", n_s == 2 && w_s0 <= 14, 1'b1);
    @(posedge ref_clk_i);
    fl.cs_gt_0p55 <= 1'b1;
    fl.cs_lt_0p30 <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    fl.cs_gt_0p55 <= 1'b0;
    fl.cs_lt_0p30 <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    rd_reg(LSG_REG_STAT);
    chk("drop hold", d[10], 1'b1);
    chk("drop pull free", pull, 1'b0);
    win(1);
    win(1);
    chk("drop restart", n_s == 2 && w_s0 <= 14, 1'b1);
    @(posedge ref_clk_i);
    fl.ss_gt_1p9 <= 1'b0;
    fl.ss_lt_1p8 <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    fl.ss_gt_1p9 <= 1'b1;
    fl.ss_lt_1p8 <= 1'b0;
    repeat (12) @(posedge ref_clk_i);
    #1 chk("ocp wait pull", pull, 1'b1);
    repeat (16) @(posedge ref_clk_i);
    #1 chk("ocp restart pull", pull, 1'b0);
    $display("test protection done");
  endtask : t_prot

  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  initial begin
    fl            = '0;
    fl.cs_hi_leave = 1'b1;
    fl.cs_lt_0p6  = 1'b1;
    fl.cs_lt_0p30 = 1'b1;
    fl.fb_gt_0p15 = 1'b1;
    fl.fb_gt_0p7  = 1'b1;
    fl.ss_lt_1p8  = 1'b1;
    fl.opt_gt_1p0 = 1'b1;
    #3 chk("gates in reset", {gate, sr}, 4'h0);
    chk("pull in reset", pull, 1'b1);
    repeat (5) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    rd_reg(LSG_REG_CTRL);
    chk("ctrl reset", d, 32'h3);
    wr_reg(8'h08, 32'hFF);
    rd_reg(8'h08);
    chk("unmapped read", d, 32'h0);
    $display("test registers done");
    t_skip();
    t_pg();
    t_sr();
    t_prot();
    end_sim();
  end
endmodule : tb_top
